// file: verilog/core_sfr_pkg.sv
/*
 * Shared constants and types for the core register and memory block:
 * register addresses, field positions, reset values, memory sizes,
 * the register-bus address map and the core-side operation carrier.
 * Assumes it is compiled before every file that imports it.
 */
package core_sfr_pkg;

    // Special function register addresses (direct address space)
    localparam logic [7:0] SFR_BASE = 8'h80;
    localparam logic [7:0] STACK_POINTER_ADDR = 8'h81;
    localparam logic [7:0] DATA_POINTER0_LOW_ADDR = 8'h82;
    localparam logic [7:0] DATA_POINTER0_HIGH_ADDR = 8'h83;
    localparam logic [7:0] DATA_POINTER1_LOW_ADDR = 8'h84;
    localparam logic [7:0] DATA_POINTER1_HIGH_ADDR = 8'h85;
    localparam logic [7:0] CORE_MODE_CONTROL_ADDR = 8'h87;
    localparam logic [7:0] POINTER_SELECT_ADDR = 8'h92;
    localparam logic [7:0] PAGED_DATA_HIGH_BYTE_ADDR = 8'hc9;
    localparam logic [7:0] PROGRAM_STATUS_ADDR = 8'hd0;
    localparam logic [7:0] MAIN_OPERAND_REG_ADDR = 8'he0;
    localparam logic [7:0] SECOND_OPERAND_REG_ADDR = 8'hf0;

    // Program status fields
    localparam int PSW_CARRY = 7;
    localparam int PSW_HALF_CARRY = 6;
    localparam int PSW_BANK_HI = 4;
    localparam int PSW_BANK_LO = 3;
    localparam int PSW_EXCESS = 2;
    localparam int PSW_PARITY = 0;

    // Mode control and pointer select fields
    localparam int MODE_BAUD_DOUBLE = 7;
    localparam int MODE_CODE_TARGET = 4;
    localparam logic [7:0] MODE_ZERO_MASK = 8'h03;
    localparam logic [7:0] SELECT_MASK = 8'h01;
    localparam int SELECT_BIT = 0;

    // Memory organisation
    localparam int INTERNAL_DATA_RAM_BYTES = 256;
    localparam logic [7:0] BIT_AREA_BASE = 8'h20;
    localparam logic [7:0] BIT_AREA_LIMIT = 8'h80;
    localparam logic [2:0] BIT_SFR_COLUMN = 3'h0;
    localparam logic [16:0] CODE_SPACE_BYTES = 17'h10000;
    localparam logic [16:0] DATA_SPACE_BYTES = 17'h10000;
    localparam logic [16:0] FLASH_BYTES = 17'h04000;
    localparam logic [16:0] SRAM_BYTES = 17'h00400;
    localparam logic [16:0] NV_STANDARD_BYTES = 17'h00400;
    localparam logic [16:0] NV_EXTENDED_BYTES = 17'h00200;

    // Register bus map: byte address = region, index and two zero bits
    localparam logic [1:0] REGION_DIRECT = 2'h0;
    localparam logic [1:0] REGION_INDIRECT = 2'h1;
    localparam logic [1:0] REGION_BIT = 2'h2;

    typedef enum logic [1:0] {
        APB_IDLE = 2'h1,
        APB_ACCESS = 2'h2
    } apb_state_type;

    // Operation requested by the execution unit in one cycle
    typedef struct packed {
        logic acc_we;
        logic [7:0] acc_wdata;
        logic b_we;
        logic [7:0] b_wdata;
        logic carry_we;
        logic carry;
        logic half_carry_we;
        logic half_carry;
        logic excess_we;
        logic excess;
        logic push;
        logic pop;
        logic [7:0] push_data;
        logic active_data_pointer_inc;
        logic ext_req;
        logic ext_use_active_data_pointer;
        logic ext_sel_r1;
        logic [2:0] reg_index;
    } core_op_type;

    typedef struct packed {
        logic [7:0] stack_pointer;
        logic [7:0] data_pointer0_low;
        logic [7:0] data_pointer0_high;
        logic [7:0] data_pointer1_low;
        logic [7:0] data_pointer1_high;
        logic [7:0] core_mode_control;
        logic [7:0] pointer_select;
        logic [7:0] paged_data_high_byte;
        logic [7:0] program_status;
        logic [7:0] main_operand_reg;
        logic [7:0] second_operand_reg;
    } sfr_type;

    localparam sfr_type SFR_RESET = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

endpackage

// file: verilog/bank_addr.sv
/*
 * Working register locator: turns a bank select and a register
 * number into an internal RAM byte address.
 * Assumes a bank select and register number from the same clock domain.
 */
`timescale 1ns/1ns
module bank_addr
    import core_sfr_pkg::*;
(
    // Operand
    input wire logic [1:0] bank_select,
    input wire logic [2:0] reg_index,
    // Result
    output logic [7:0] internal_data_ram_addr
);
    // Four banks of eight bytes at the bottom of internal RAM
    assign internal_data_ram_addr = {3'h0, bank_select, reg_index}; // see [RULE_06] see [RULE_10]
endmodule

// file: verilog/bit_locate.sv
/*
 * Bit address locator: maps an 8-bit bit address onto a direct byte
 * address and a bit position inside it.
 * Assumes the caller checks that a located register exists.
 */
`timescale 1ns/1ns
module bit_locate
    import core_sfr_pkg::*;
(
    // Bit address
    input wire logic [7:0] bit_addr,
    // Location
    output logic [7:0] byte_addr,
    output logic [2:0] bit_index,
    output logic in_sfr
);
    // Low half walks the bit area byte by byte, high half the X000 column
    always_comb begin
        in_sfr = (bit_addr >= BIT_AREA_LIMIT);
        bit_index = bit_addr[2:0];
        if (in_sfr) begin
            byte_addr = {bit_addr[7:3], BIT_SFR_COLUMN}; // see [RULE_23]
        end else begin
            byte_addr = BIT_AREA_BASE + {4'h0, bit_addr[6:3]}; // see [RULE_07]
        end
    end
endmodule

// file: verilog/core_sfr_regs.sv
/*
 * Core register file and internal RAM of the 8-bit controller, with
 * stack, data pointers, paged external addressing and an APB slave.
 * Assumes the execution unit and the APB master share clk, so no
 * input is synchronised, and that software avoids unmapped locations.
 */
// Our own choice: the APB register port.
`timescale 1ns/1ns

// Operation
// [RULE_01] 64 kB code/data, 256 B RAM, 128 B SFRs
// [RULE_02] Default 16k flash, 1k SRAM, NV blocks
// [RULE_03] Software avoids unmapped memory map areas
// [RULE_04] Low RAM: registers 0x00-0x1F, bits 0x20-0x2F
// [RULE_05] Upper RAM indirect only; direct hits SFRs
// [RULE_06] Four banks of eight registers, status-selected
// [RULE_07] Bit addresses 0x00-0x7F cover bytes 0x20-0x2F
// [RULE_08] Page register supplies high address byte
// [RULE_09] Status carry, half carry and overflow bits
// [RULE_10] Status bits 4-3 pick register bank
// [RULE_11] Parity bit follows accumulator, software cannot write
// [RULE_12] Status bits 5 and 1 are user flags
// [RULE_13] Stack pre-increments on push, post-decrements on pop
// [RULE_14] Pointer zero is 16-bit, bytes 0x82/0x83
// [RULE_15] Pointer one is 16-bit, bytes 0x84/0x85
// [RULE_16] Select bit 0 picks pointer; others unused
// [RULE_17] Mode bit 4 steers external moves to code
// [RULE_18] Mode bit 7 drives serial baud doubler
// [RULE_19] Mode bits 6,5,3,2 are spare flags
// [RULE_20] Mode bits 1:0 read zero, written zero
// [RULE_21] Second operand register serves multiply/divide, scratch
// [RULE_22] Accumulator at 0xE0, bit addressable
// [RULE_23] Only X000 registers are bit addressable
// [RULE_24] Second operand, pointer high, select reset zero
// [RULE_25] Parity updates with the accumulator, never stale
module core_sfr_regs
    import core_sfr_pkg::*;
(
    // Clock, reset and enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Execution unit
    input wire core_op_type core_op,
    output logic [7:0] acc_value,
    output logic [7:0] b_value,
    output logic [7:0] status_value,
    output logic [7:0] reg_rdata,
    output logic [7:0] pop_data,
    output logic [15:0] active_data_pointer,
    // External data access
    output logic [15:0] ext_addr,
    output logic ext_to_code,
    output logic ext_unmapped,
    // Serial port
    output logic baud_double
);

    typedef struct packed {
        sfr_type sfr;
        logic [INTERNAL_DATA_RAM_BYTES-1:0][7:0] internal_data_ram;
        apb_state_type apb;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [7:0] reg_rdata;
        logic [7:0] pop_data;
        logic [15:0] ext_addr;
        logic ext_to_code;
        logic ext_unmapped;
        logic [15:0] active_data_pointer;
        logic baud_double;
    } core_state_type;

    core_state_type state;
    core_state_type next_state;

    logic [1:0] bus_region;
    logic [7:0] bus_index;
    logic [7:0] bit_byte;
    logic [2:0] bit_index;
    logic bit_in_sfr;
    logic [7:0] operand_addr;
    logic [7:0] pointer_reg_addr;
    logic dec_err;
    logic dec_indirect;
    logic [7:0] dec_addr;
    logic [7:0] dec_rdata;
    logic apb_take_wr;

    assign bus_region = paddr[11:10];
    assign bus_index = paddr[9:2];

    // Bit addresses come straight from the bus index
    bit_locate u_bit_locate (
        .bit_addr(bus_index),
        .byte_addr(bit_byte),
        .bit_index(bit_index),
        .in_sfr(bit_in_sfr)
    );

    // Register operand of the running instruction
    bank_addr u_operand_addr (
        .bank_select(state.sfr.program_status[PSW_BANK_HI:PSW_BANK_LO]),
        .reg_index(core_op.reg_index),
        .internal_data_ram_addr(operand_addr)
    );

    // R0 or R1 of the current bank for paged accesses
    bank_addr u_pointer_addr (
        .bank_select(state.sfr.program_status[PSW_BANK_HI:PSW_BANK_LO]),
        .reg_index({2'h0, core_op.ext_sel_r1}),
        .internal_data_ram_addr(pointer_reg_addr)
    );

    // Registers that exist in the special function space
    function automatic logic sfr_mapped(input logic [7:0] a);
        case (a)
            STACK_POINTER_ADDR, DATA_POINTER0_LOW_ADDR, DATA_POINTER0_HIGH_ADDR,
            DATA_POINTER1_LOW_ADDR, DATA_POINTER1_HIGH_ADDR,
            CORE_MODE_CONTROL_ADDR, POINTER_SELECT_ADDR,
            PAGED_DATA_HIGH_BYTE_ADDR, PROGRAM_STATUS_ADDR,
            MAIN_OPERAND_REG_ADDR, SECOND_OPERAND_REG_ADDR: sfr_mapped = 1'b1;
            default: sfr_mapped = 1'b0;
        endcase
    endfunction

    function automatic logic [7:0] read_sfr(input sfr_type s, input logic [7:0] a);
        case (a)
            STACK_POINTER_ADDR: read_sfr = s.stack_pointer;
            DATA_POINTER0_LOW_ADDR: read_sfr = s.data_pointer0_low; // see [RULE_14]
            DATA_POINTER0_HIGH_ADDR: read_sfr = s.data_pointer0_high;
            DATA_POINTER1_LOW_ADDR: read_sfr = s.data_pointer1_low; // see [RULE_15]
            DATA_POINTER1_HIGH_ADDR: read_sfr = s.data_pointer1_high;
            CORE_MODE_CONTROL_ADDR: read_sfr = s.core_mode_control & ~MODE_ZERO_MASK;
            POINTER_SELECT_ADDR: read_sfr = s.pointer_select & SELECT_MASK;
            PAGED_DATA_HIGH_BYTE_ADDR: read_sfr = s.paged_data_high_byte;
            PROGRAM_STATUS_ADDR: read_sfr = s.program_status;
            MAIN_OPERAND_REG_ADDR: read_sfr = s.main_operand_reg; // see [RULE_22]
            SECOND_OPERAND_REG_ADDR: read_sfr = s.second_operand_reg; // see [RULE_21]
            default: read_sfr = 8'h00;
        endcase
    endfunction

    // Software writes; parity and unused bits cannot be set from here
    function automatic sfr_type write_sfr(input sfr_type s, input logic [7:0] a,
                                          input logic [7:0] d);
        write_sfr = s;
        case (a)
            STACK_POINTER_ADDR: write_sfr.stack_pointer = d;
            DATA_POINTER0_LOW_ADDR: write_sfr.data_pointer0_low = d;
            DATA_POINTER0_HIGH_ADDR: write_sfr.data_pointer0_high = d;
            DATA_POINTER1_LOW_ADDR: write_sfr.data_pointer1_low = d;
            DATA_POINTER1_HIGH_ADDR: write_sfr.data_pointer1_high = d;
            CORE_MODE_CONTROL_ADDR: write_sfr.core_mode_control = d & ~MODE_ZERO_MASK; // see [RULE_19] see [RULE_20]
            POINTER_SELECT_ADDR: write_sfr.pointer_select = d & SELECT_MASK; // see [RULE_16]
            PAGED_DATA_HIGH_BYTE_ADDR: write_sfr.paged_data_high_byte = d;
            PROGRAM_STATUS_ADDR: write_sfr.program_status =
                {d[7:1], s.program_status[PSW_PARITY]}; // see [RULE_11] see [RULE_12]
            MAIN_OPERAND_REG_ADDR: write_sfr.main_operand_reg = d;
            SECOND_OPERAND_REG_ADDR: write_sfr.second_operand_reg = d;
            default: write_sfr = s;
        endcase
    endfunction

    // Decode of the bus address into a direct or indirect byte
    always_comb begin
        dec_err = 1'b0;
        dec_indirect = 1'b0;
        dec_addr = bus_index;
        dec_rdata = 8'h00;
        case (bus_region)
            REGION_DIRECT: begin
                // Direct addresses at or above the SFR base never reach RAM
                if (bus_index < SFR_BASE) begin
                    dec_rdata = state.internal_data_ram[bus_index]; // see [RULE_04]
                end else begin
                    dec_err = !sfr_mapped(bus_index); // see [RULE_05]
                    dec_rdata = read_sfr(state.sfr, bus_index);
                end
            end
            REGION_INDIRECT: begin
                dec_indirect = 1'b1;
                dec_rdata = state.internal_data_ram[bus_index]; // see [RULE_01] see [RULE_05]
            end
            REGION_BIT: begin
                dec_addr = bit_byte;
                if (bit_in_sfr) begin
                    dec_err = !sfr_mapped(bit_byte); // see [RULE_23]
                    dec_rdata = read_sfr(state.sfr, bit_byte);
                end else begin
                    dec_rdata = state.internal_data_ram[bit_byte];
                end
            end
            default: dec_err = 1'b1; // see [RULE_03]
        endcase
    end

    assign apb_take_wr = (state.apb == APB_ACCESS) && psel && penable && pwrite &&
                         state.pready && !state.pslverr;

    // Next state: execution unit first, then the bus, then parity
    always_comb begin
        logic [7:0] wr_byte;
        logic [15:0] ptr;
        logic [7:0] sp_up;
        wr_byte = 8'h00;
        ptr = 16'h0000;
        sp_up = 8'h00;
        next_state = state;
        if (core_op.acc_we) begin
            next_state.sfr.main_operand_reg = core_op.acc_wdata;
        end
        if (core_op.b_we) begin
            next_state.sfr.second_operand_reg = core_op.b_wdata;
        end
        // Arithmetic flags
        if (core_op.carry_we) begin
            next_state.sfr.program_status[PSW_CARRY] = core_op.carry; // see [RULE_09]
        end
        if (core_op.half_carry_we) begin
            next_state.sfr.program_status[PSW_HALF_CARRY] = core_op.half_carry;
        end
        if (core_op.excess_we) begin
            next_state.sfr.program_status[PSW_EXCESS] = core_op.excess;
        end
        // Stack: increment before storing, read before decrementing
        sp_up = state.sfr.stack_pointer + 8'h01;
        if (core_op.push) begin
            next_state.sfr.stack_pointer = sp_up; // see [RULE_13]
            next_state.internal_data_ram[sp_up] = core_op.push_data;
        end else if (core_op.pop) begin
            next_state.pop_data = state.internal_data_ram[state.sfr.stack_pointer];
            next_state.sfr.stack_pointer = state.sfr.stack_pointer - 8'h01; // see [RULE_13]
        end
        // Active pointer increment
        if (core_op.active_data_pointer_inc) begin
            if (state.sfr.pointer_select[SELECT_BIT]) begin
                ptr = {state.sfr.data_pointer1_high, state.sfr.data_pointer1_low} + 16'h0001;
                next_state.sfr.data_pointer1_high = ptr[15:8];
                next_state.sfr.data_pointer1_low = ptr[7:0];
            end else begin
                ptr = {state.sfr.data_pointer0_high, state.sfr.data_pointer0_low} + 16'h0001;
                next_state.sfr.data_pointer0_high = ptr[15:8];
                next_state.sfr.data_pointer0_low = ptr[7:0];
            end
        end
        // External move address, target space and range check
        if (core_op.ext_req) begin
            if (core_op.ext_use_active_data_pointer) begin
                next_state.ext_addr = state.active_data_pointer;
            end else begin
                next_state.ext_addr = {state.sfr.paged_data_high_byte,
                                       state.internal_data_ram[pointer_reg_addr]}; // see [RULE_08]
            end
            next_state.ext_to_code = state.sfr.core_mode_control[MODE_CODE_TARGET]; // see [RULE_17]
            if (state.sfr.core_mode_control[MODE_CODE_TARGET]) begin
                next_state.ext_unmapped = ({1'b0, next_state.ext_addr} >= FLASH_BYTES); // see [RULE_02]
            end else begin
                next_state.ext_unmapped = ({1'b0, next_state.ext_addr} >= SRAM_BYTES);
            end
        end
        next_state.reg_rdata = state.internal_data_ram[operand_addr]; // see [RULE_06]
        // Bus slave; a bus write lands after the core so software wins a tie
        case (state.apb)
            APB_IDLE: begin
                if (psel && !penable) begin
                    next_state.apb = APB_ACCESS;
                    next_state.pready = 1'b1;
                    next_state.pslverr = dec_err;
                    next_state.prdata = dec_err ? 32'h0000_0000 : {24'h00_0000, dec_rdata};
                end
            end
            APB_ACCESS: begin
                if (psel && penable && state.pready) begin
                    next_state.apb = APB_IDLE;
                    next_state.pready = 1'b0;
                    next_state.pslverr = 1'b0;
                    if (apb_take_wr) begin
                        wr_byte = pwdata[7:0];
                        if (bus_region == REGION_BIT) begin
                            wr_byte = dec_rdata;
                            wr_byte[bit_index] = pwdata[0]; // see [RULE_07] see [RULE_22]
                        end
                        if (dec_indirect || dec_addr < SFR_BASE) begin
                            next_state.internal_data_ram[dec_addr] = wr_byte;
                        end else begin
                            next_state.sfr = write_sfr(next_state.sfr, dec_addr, wr_byte);
                        end
                    end
                end
            end
            default: begin
                next_state.apb = APB_IDLE;
                next_state.pready = 1'b0;
            end
        endcase
        // Parity always follows the final accumulator value of the cycle
        next_state.sfr.program_status[PSW_PARITY] =
            ^next_state.sfr.main_operand_reg; // see [RULE_11] see [RULE_25]
        next_state.active_data_pointer = next_state.sfr.pointer_select[SELECT_BIT] ?
            {next_state.sfr.data_pointer1_high, next_state.sfr.data_pointer1_low} :
            {next_state.sfr.data_pointer0_high, next_state.sfr.data_pointer0_low}; // see [RULE_16]
        next_state.baud_double = next_state.sfr.core_mode_control[MODE_BAUD_DOUBLE]; // see [RULE_18]
    end

    // State register; a low enable freezes everything
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= '0;
            state.sfr <= SFR_RESET; // see [RULE_24]
            state.apb <= APB_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // Outputs straight from the state flops
    assign prdata = state.prdata;
    assign pready = state.pready;
    assign pslverr = state.pslverr;
    assign acc_value = state.sfr.main_operand_reg;
    assign b_value = state.sfr.second_operand_reg;
    assign status_value = state.sfr.program_status;
    assign reg_rdata = state.reg_rdata;
    assign pop_data = state.pop_data;
    assign active_data_pointer = state.active_data_pointer;
    assign ext_addr = state.ext_addr;
    assign ext_to_code = state.ext_to_code;
    assign ext_unmapped = state.ext_unmapped;
    assign baud_double = state.baud_double;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    a_parity_tracks_acc: assert property (
        state.sfr.program_status[PSW_PARITY] == ^state.sfr.main_operand_reg) // see [RULE_11]
        else $error("parity bit disagrees with accumulator");
    a_mode_low_zero: assert property (
        (state.sfr.core_mode_control & MODE_ZERO_MASK) == 8'h00) // see [RULE_20]
        else $error("mode control bits 1:0 not zero");
    a_select_upper_zero: assert property (
        (state.sfr.pointer_select & ~SELECT_MASK) == 8'h00) // see [RULE_16]
        else $error("pointer select upper bits not zero");
    a_push_stack_grows: assert property (
        (ce && core_op.push && !apb_take_wr) |=> // see [RULE_13]
        (state.sfr.stack_pointer == $past(state.sfr.stack_pointer) + 8'h01) &&
        (state.internal_data_ram[state.sfr.stack_pointer] == $past(core_op.push_data)))
        else $error("push did not pre-increment and store");
    a_pop_stack_shrinks: assert property (
        (ce && core_op.pop && !core_op.push && !apb_take_wr) |=> // see [RULE_13]
        (state.sfr.stack_pointer == $past(state.sfr.stack_pointer) - 8'h01) &&
        (pop_data == $past(state.internal_data_ram[state.sfr.stack_pointer])))
        else $error("pop did not read top then decrement");
    a_paged_high_byte: assert property (
        (ce && core_op.ext_req && !core_op.ext_use_active_data_pointer) |=> // see [RULE_08]
        ext_addr[15:8] == $past(state.sfr.paged_data_high_byte))
        else $error("paged address high byte not from page register");
    a_code_target_mode: assert property (
        (ce && core_op.ext_req) |=> // see [RULE_17]
        ext_to_code == $past(state.sfr.core_mode_control[MODE_CODE_TARGET]))
        else $error("external target space does not follow mode bit");
    a_baud_follows_mode: assert property (
        baud_double == state.sfr.core_mode_control[MODE_BAUD_DOUBLE]) // see [RULE_18]
        else $error("baud doubler output differs from mode bit");
    a_bank_operand_read: assert property (
        ce |=> reg_rdata == $past(state.internal_data_ram[{3'h0, // see [RULE_10]
            state.sfr.program_status[PSW_BANK_HI:PSW_BANK_LO], core_op.reg_index}]))
        else $error("register operand not from selected bank");
    a_apb_ready_setup: assert property (
        (ce && psel && !penable && state.apb == APB_IDLE) |=> pready)
        else $error("setup cycle not answered with ready");

endmodule

// file: verif/core_sfr_regs_tb.sv
/* Self-checking bench for core_sfr_regs: APB register traffic plus core ops.
   Assumes one 10 MHz clock, ce held high, and the APB map in the package. */
`timescale 1ns/1ns
module core_sfr_regs_tb import core_sfr_pkg::*;;
    logic clk = 0, arst_n = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, ext_to_code, ext_unmapped, baud_double, er;
    logic [7:0] acc_value, b_value, status_value, reg_rdata, pop_data, rd;
    logic [15:0] active_data_pointer, ext_addr;
    core_op_type core_op = '0, v;
    int failures = 0, cmp_count = 0, cycles = 0;
    logic [7:0] sfrs [11] = '{STACK_POINTER_ADDR, DATA_POINTER0_LOW_ADDR,
        DATA_POINTER0_HIGH_ADDR, DATA_POINTER1_LOW_ADDR, DATA_POINTER1_HIGH_ADDR,
        CORE_MODE_CONTROL_ADDR, POINTER_SELECT_ADDR, PAGED_DATA_HIGH_BYTE_ADDR,
        PROGRAM_STATUS_ADDR, MAIN_OPERAND_REG_ADDR, SECOND_OPERAND_REG_ADDR};

    core_sfr_regs u_dut (.clk, .arst_n, .ce, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .core_op, .acc_value, .b_value,
        .status_value, .reg_rdata, .pop_data, .active_data_pointer, .ext_addr,
        .ext_to_code, .ext_unmapped, .baud_double);

    // 100 ns period
    initial begin
        forever #50 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, exp, input string nm);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    // One transfer; ends at a falling edge so the next setup is a full cycle later
    task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {a, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) failures++;
        @(negedge clk);
    endtask

    task automatic rdv(input logic [9:0] a, input logic [7:0] e, input string nm);
        apb(1'b0, a, 8'h00);
        chk(rd, e, nm);
    endtask

    // Holds a core operation for exactly one sampling edge
    task automatic op(input core_op_type o);
        @(posedge clk);
        core_op <= o;
        @(posedge clk);
        core_op <= '0;
        @(negedge clk);
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Cuts a hang short; the whole sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            give_verdict;
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        foreach (sfrs[i]) rdv({REGION_DIRECT, sfrs[i]}, 8'h00, "reset");
        $display("reset test done");
        // Mode bits 1:0 are always written as zero; only mapped places are touched
        apb(1'b1, {REGION_DIRECT, CORE_MODE_CONTROL_ADDR}, 8'hfc);
        rdv({REGION_DIRECT, CORE_MODE_CONTROL_ADDR}, 8'hfc, "mode");
        chk(baud_double, 1'b1, "baud");
        apb(1'b1, {REGION_DIRECT, POINTER_SELECT_ADDR}, 8'hff);
        rdv({REGION_DIRECT, POINTER_SELECT_ADDR}, 8'h01, "select");
        apb(1'b1, {REGION_DIRECT, DATA_POINTER1_LOW_ADDR}, 8'h12);
        apb(1'b1, {REGION_DIRECT, DATA_POINTER1_HIGH_ADDR}, 8'hab);
        chk(active_data_pointer, 16'hab12, "active_data_pointer");
        apb(1'b1, {REGION_DIRECT, SECOND_OPERAND_REG_ADDR}, 8'h3c);
        chk(b_value, 8'h3c, "second");
        apb(1'b1, {REGION_DIRECT, PROGRAM_STATUS_ADDR}, 8'hf7);
        rdv({REGION_DIRECT, PROGRAM_STATUS_ADDR}, 8'hf6, "status");
        apb(1'b1, {REGION_DIRECT, MAIN_OPERAND_REG_ADDR}, 8'h07);
        chk(status_value, 8'hf7, "parity");
        apb(1'b1, {REGION_BIT, 8'he3}, 8'h01);
        chk(acc_value, 8'h0f, "acc bit");
        $display("register test done");
        apb(1'b1, {REGION_INDIRECT, 8'h13}, 8'h5a);
        v = '0;
        v.reg_index = 3'h3;
        op(v);
        chk(reg_rdata, 8'h5a, "bank");
        apb(1'b1, {REGION_BIT, 8'h09}, 8'h01);
        rdv({REGION_INDIRECT, 8'h21}, 8'h02, "bit area");
        // Upper RAM byte and the register at the same direct address stay apart
        apb(1'b1, {REGION_INDIRECT, 8'he0}, 8'h66);
        rdv({REGION_DIRECT, 8'he0}, 8'h0f, "direct upper");
        chk(er, 1'b0, "direct err");
        rdv({REGION_INDIRECT, 8'he0}, 8'h66, "indirect upper");
        $display("memory test done");
        apb(1'b1, {REGION_DIRECT, PAGED_DATA_HIGH_BYTE_ADDR}, 8'h80);
        apb(1'b1, {REGION_INDIRECT, 8'h10}, 8'h34);
        v = '0;
        v.ext_req = 1'b1;
        op(v);
        chk(ext_addr, 16'h8034, "paged");
        chk(ext_to_code, 1'b1, "code target");
        chk(ext_unmapped, 1'b1, "beyond flash");
        v.ext_use_active_data_pointer = 1'b1;
        op(v);
        chk(ext_addr, 16'hab12, "active_data_pointer ext");
        v = '0;
        v.push = 1'b1;
        v.push_data = 8'ha5;
        op(v);
        rdv({REGION_DIRECT, STACK_POINTER_ADDR}, 8'h01, "sp push");
        rdv({REGION_INDIRECT, 8'h01}, 8'ha5, "stacked");
        v = '0;
        v.pop = 1'b1;
        op(v);
        chk(pop_data, 8'ha5, "pop");
        rdv({REGION_DIRECT, STACK_POINTER_ADDR}, 8'h00, "sp pop");
        $display("core op test done");
        give_verdict;
    end
endmodule
